//--- rtl/smc_sleep_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// - active mode plus idle, standby, power-down
// - sleep halts cpu; interrupt wakes, resumes
// - any reset leaves sleep, restarts at vector
// - registers and memory retained while asleep
// - no enabled interrupt: only reset or debug break wakes
// - idle stops cpu clock, any interrupt wakes
// - standby keeps peripherals per run-in-standby
// - power-down keeps monitor, watchdog, periodic timer
// - peripheral clock only in idle
// - main oscillator gating per sleep mode
// - wake sources qualified per sleep mode
// - configurable logic wakes power-down only clockless
// - wake takes six clocks plus oscillator start
// - power-down clocks off except low-power ones
// - fuse 0x3 waits for brown-out monitor ready
// - mode codes idle 0, standby 1, power-down 2
// - debug break wakes to active mode
module smc_sleep_sequencer #(
  parameter int WAKE_CYCLES = smc_pkg::WAKE_CLK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [2:0] ctrlWrData,
  input wire logic ctrlWrEn,
  input wire logic sleepInstr,
  input wire smc_pkg::smc_wake_src_t wakeSrc,
  input wire smc_pkg::smc_standby_t runInStandby,
  input wire logic debugBreak,
  input wire logic oscReady,
  input wire logic [1:0] brownoutConfigFuse,
  input wire logic brownoutReady,
  output logic [2:0] ctrlRdData,
  output smc_pkg::smc_gates_t gates,
  output logic asleep,
  output logic [1:0] activeSleepMode,
  output logic wakeDone
);
  logic sleepEnableBit;
  logic [1:0] sleepModeSelect;
  logic next_sleepEnableBit;
  logic [1:0] next_sleepModeSelect;
  smc_pkg::smc_state_t state;
  smc_pkg::smc_state_t next_state;
  logic [1:0] mode;
  logic [1:0] next_mode;
  logic [smc_pkg::WAKE_CNT_W-1:0] wakeCnt;
  logic [smc_pkg::WAKE_CNT_W-1:0] next_wakeCnt;
  smc_pkg::smc_gates_t next_gates;
  logic wakeReq;
  logic needOsc;
  logic countDone;

  // qualify one wake source against the mode in force
  function automatic logic wakeAllowed(input logic [1:0] m, input logic canIdle,
                                       input logic canStandby, input logic canPowerDown);
    wakeAllowed = (m == smc_pkg::MODE_IDLE) ? canIdle :
                  (m == smc_pkg::MODE_STANDBY) ? canStandby :
                  (m == smc_pkg::MODE_POWER_DOWN) ? canPowerDown : 1'b0;
  endfunction

  always_comb
  begin
    next_sleepEnableBit = sleepEnableBit;
    next_sleepModeSelect = sleepModeSelect;
    if (ctrlWrEn)
    begin
      next_sleepEnableBit = ctrlWrData[smc_pkg::CTRL_EN_POS];
      next_sleepModeSelect = ctrlWrData[smc_pkg::CTRL_MODE_POS +: 2];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sleepEnableBit <= smc_pkg::CTRL_RESET[smc_pkg::CTRL_EN_POS];
      sleepModeSelect <= smc_pkg::CTRL_RESET[smc_pkg::CTRL_MODE_POS +: 2];
    end
    else
    begin
      sleepEnableBit <= next_sleepEnableBit;
      sleepModeSelect <= next_sleepModeSelect;
    end
  end

  assign ctrlRdData = {sleepModeSelect, sleepEnableBit};

  always_comb
  begin
    wakeReq = 1'b0;
    wakeReq = wakeReq | wakeSrc.pinChange | wakeSrc.extInt | wakeSrc.twoWireAddrMatch | wakeSrc.periodicTimer;
    wakeReq = wakeReq | wakeAllowed(mode, 1'b1, 1'b1, 1'b1) & wakeSrc.voltageMonitor;
    wakeReq = wakeReq | wakeAllowed(mode, 1'b1, runInStandby.configLogic, wakeSrc.configLogicNoClk)
              & wakeSrc.configLogic;
    wakeReq = wakeReq | wakeAllowed(mode, 1'b1, runInStandby.serial, 1'b0) & wakeSrc.serialStartFrame;
    wakeReq = wakeReq | wakeAllowed(mode, 1'b1, runInStandby.timerB, 1'b0) & wakeSrc.timerB;
    wakeReq = wakeReq | wakeAllowed(mode, 1'b1, runInStandby.adc, 1'b0) & wakeSrc.adcWindow;
    wakeReq = wakeReq | wakeAllowed(mode, 1'b1, runInStandby.comparator, 1'b0) & wakeSrc.comparator;
    wakeReq = wakeReq | wakeAllowed(mode, 1'b1, runInStandby.rtc, 1'b0) & wakeSrc.rtc;
    wakeReq = wakeReq | wakeAllowed(mode, 1'b1, 1'b0, 1'b0) & wakeSrc.other;
  end

  assign needOsc = (mode != smc_pkg::MODE_IDLE) && !(mode == smc_pkg::MODE_STANDBY && runInStandby.mainOsc);
  assign countDone = (wakeCnt == smc_pkg::WAKE_CNT_W'(WAKE_CYCLES - 1));

  always_comb
  begin
    next_state = state;
    next_mode = mode;
    next_wakeCnt = wakeCnt;
    case (state)
      smc_pkg::SMC_ACTIVE:
      begin
        next_wakeCnt = '0;
        // sleep instruction with enable; reserved code refused
        if (sleepInstr && sleepEnableBit && sleepModeSelect != 2'h3)
        begin
          next_state = smc_pkg::SMC_SLEEP;
          next_mode = sleepModeSelect;
        end
      end
      smc_pkg::SMC_SLEEP:
      begin
        // nothing enabled keeps it here; break wakes
        if (wakeReq || debugBreak)
        begin
          next_state = smc_pkg::SMC_WAKING;
        end
      end
      smc_pkg::SMC_WAKING:
      begin
        if (!countDone && (oscReady || !needOsc))
        begin
          next_wakeCnt = wakeCnt + 1'b1;
        end
        if (countDone && (brownoutConfigFuse != smc_pkg::BROWNOUT_WAIT_READY || brownoutReady))
        begin
          next_state = smc_pkg::SMC_ACTIVE;
        end
      end
      default:
      begin
        next_state = smc_pkg::SMC_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= smc_pkg::SMC_ACTIVE;
      mode <= smc_pkg::MODE_IDLE;
      wakeCnt <= '0;
    end
    else
    begin
      state <= next_state;
      mode <= next_mode;
      wakeCnt <= next_wakeCnt;
    end
  end

  // clock gates per mode; oscillator requested again during wake
  always_comb
  begin
    next_gates = '1;
    if (next_state == smc_pkg::SMC_SLEEP)
    begin
      // cpu halted; nothing is reset so state is kept
      next_gates.cpuClk = 1'b0;
      case (next_mode)
        smc_pkg::MODE_STANDBY:
        begin
          next_gates.peripheralClock = 1'b0;
          next_gates.rtcRun = runInStandby.rtc;
          next_gates.configLogicRun = runInStandby.configLogic;
          next_gates.adcRun = runInStandby.adc;
          next_gates.timerBRun = runInStandby.timerB;
          next_gates.mainOscOn = runInStandby.mainOsc;
          next_gates.rtcOscOn = runInStandby.rtcOsc;
        end
        smc_pkg::MODE_POWER_DOWN:
        begin
          next_gates.peripheralClock = 1'b0;
          next_gates.rtcRun = 1'b0;
          next_gates.configLogicRun = 1'b0;
          next_gates.adcRun = 1'b0;
          next_gates.timerBRun = 1'b0;
          next_gates.mainOscOn = 1'b0;
          next_gates.rtcOscOn = 1'b1;
        end
        default:
        begin
          next_gates.cpuClk = 1'b0;
        end
      endcase
    end
    else if (next_state == smc_pkg::SMC_WAKING)
    begin
      next_gates.cpuClk = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gates <= '1;
      wakeDone <= 1'b0;
    end
    else
    begin
      gates <= next_gates;
      wakeDone <= (state == smc_pkg::SMC_WAKING) && (next_state == smc_pkg::SMC_ACTIVE);
    end
  end

  assign asleep = (state != smc_pkg::SMC_ACTIVE);
  assign activeSleepMode = mode;

  property p_idle_peripherals;
    @(posedge ref_clk) disable iff (!rstn)
      (state == smc_pkg::SMC_SLEEP && mode == smc_pkg::MODE_IDLE) |-> gates.peripheralClock && !gates.cpuClk;
  endproperty
  a_idle_peripherals: assert property (p_idle_peripherals) else $error("idle gating wrong");

  property p_power_down_off;
    @(posedge ref_clk) disable iff (!rstn)
      (state == smc_pkg::SMC_SLEEP && mode == smc_pkg::MODE_POWER_DOWN) |-> !gates.mainOscOn && !gates.peripheralClock;
  endproperty
  a_power_down_off: assert property (p_power_down_off) else $error("power-down clock left on");

  property p_enter;
    @(posedge ref_clk) disable iff (!rstn)
      (state == smc_pkg::SMC_ACTIVE && sleepInstr && sleepEnableBit && sleepModeSelect != 2'h3)
      |=> state == smc_pkg::SMC_SLEEP && mode == $past(sleepModeSelect);
  endproperty
  a_enter: assert property (p_enter) else $error("sleep not entered");

  property p_no_enable;
    @(posedge ref_clk) disable iff (!rstn)
      (state == smc_pkg::SMC_ACTIVE && !sleepEnableBit) |=> state == smc_pkg::SMC_ACTIVE;
  endproperty
  a_no_enable: assert property (p_no_enable) else $error("slept without enable");

  property p_stay;
    @(posedge ref_clk) disable iff (!rstn)
      (state == smc_pkg::SMC_SLEEP && !wakeReq && !debugBreak) |=> state == smc_pkg::SMC_SLEEP;
  endproperty
  a_stay: assert property (p_stay) else $error("woke with no source");

  property p_break;
    @(posedge ref_clk) disable iff (!rstn)
      (state == smc_pkg::SMC_SLEEP && debugBreak) |=> state == smc_pkg::SMC_WAKING;
  endproperty
  a_break: assert property (p_break) else $error("break did not wake");

  property p_idle_wake_time;
    @(posedge ref_clk) disable iff (!rstn)
      (state == smc_pkg::SMC_SLEEP && mode == smc_pkg::MODE_IDLE && wakeReq
       && brownoutConfigFuse != smc_pkg::BROWNOUT_WAIT_READY) |-> ##[1:7] wakeDone;
  endproperty
  a_idle_wake_time: assert property (p_idle_wake_time) else $error("idle wake too slow");

  property p_monitor_wait;
    @(posedge ref_clk) disable iff (!rstn)
      (state == smc_pkg::SMC_WAKING && brownoutConfigFuse == smc_pkg::BROWNOUT_WAIT_READY && !brownoutReady)
      |=> state != smc_pkg::SMC_ACTIVE;
  endproperty
  a_monitor_wait: assert property (p_monitor_wait) else $error("woke before monitor ready");

  // judged on the raw sources, so a wrongly qualified source cannot hide behind wakeReq
  property p_power_down_src;
    @(posedge ref_clk) disable iff (!rstn)
      (state == smc_pkg::SMC_SLEEP && mode == smc_pkg::MODE_POWER_DOWN && !debugBreak
       && !(wakeSrc.pinChange || wakeSrc.extInt || wakeSrc.twoWireAddrMatch || wakeSrc.periodicTimer
       || wakeSrc.voltageMonitor || (wakeSrc.configLogic && wakeSrc.configLogicNoClk)))
      |=> state == smc_pkg::SMC_SLEEP;
  endproperty
  a_power_down_src: assert property (p_power_down_src) else $error("power-down woken by other");

  c_idle: cover property (@(posedge ref_clk) disable iff (!rstn) wakeDone && mode == smc_pkg::MODE_IDLE);
  c_standby: cover property (@(posedge ref_clk) disable iff (!rstn) wakeDone && mode == smc_pkg::MODE_STANDBY);
  c_power_down: cover property (@(posedge ref_clk) disable iff (!rstn) wakeDone && mode == smc_pkg::MODE_POWER_DOWN);
  c_break: cover property (@(posedge ref_clk) disable iff (!rstn) state == smc_pkg::SMC_SLEEP && debugBreak);
endmodule // smc_sleep_sequencer

//--- pkg/smc_pkg.sv
package smc_pkg;
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_STANDBY = 2'h1;
  localparam logic [1:0] MODE_POWER_DOWN = 2'h2;
  localparam int CTRL_EN_POS = 0;
  localparam int CTRL_MODE_POS = 1;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] BROWNOUT_WAIT_READY = 2'h3;
  localparam int WAKE_CLK_CYCLES = 6;
  localparam int WAKE_CNT_W = 4;

  typedef enum logic [1:0] {
    SMC_ACTIVE,
    SMC_SLEEP,
    SMC_WAKING
  } smc_state_t;

  // wake interrupt sources, each already gated by its own enable
  typedef struct packed {
    logic pinChange;
    logic extInt;
    logic twoWireAddrMatch;
    logic periodicTimer;
    logic voltageMonitor;
    logic configLogic;
    logic configLogicNoClk;
    logic serialStartFrame;
    logic timerB;
    logic adcWindow;
    logic comparator;
    logic rtc;
    logic other;
  } smc_wake_src_t;

  // run-in-standby settings of peripherals and clock sources
  typedef struct packed {
    logic rtc;
    logic configLogic;
    logic adc;
    logic timerB;
    logic serial;
    logic comparator;
    logic mainOsc;
    logic rtcOsc;
  } smc_standby_t;

  // clock and run gates towards the system
  typedef struct packed {
    logic cpuClk;
    logic peripheralClock;
    logic rtcRun;
    logic configLogicRun;
    logic adcRun;
    logic timerBRun;
    logic mainOscOn;
    logic rtcOscOn;
  } smc_gates_t;
endpackage

//--- bench/smc_osc_model.sv
`timescale 1ns/1ps
// main oscillator seen by the sequencer: not ready until start-up has run out
module smc_osc_model #(
  parameter int START = 5
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic oscOn,
  output logic oscReady
);
  int cnt;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      cnt <= START;
    else if (!oscOn)
      cnt <= 0;
    else if (cnt < START)
      cnt <= cnt + 1;
  end
  assign oscReady = oscOn && cnt >= START;
endmodule // smc_osc_model

//--- bench/smc_sleep_sequencer_tb_top.sv
`timescale 1ns/1ps
module smc_sleep_sequencer_tb_top;
  localparam int OSC_START = 5;
  logic ref_clk = 0, rstn = 0, ctrlWrEn = 0, sleepInstr = 0, debugBreak = 0, brownoutReady = 1;
  logic [2:0] ctrlWrData = '0;
  logic [2:0] ctrlRdData;
  logic [1:0] brownoutConfigFuse = '0;
  logic [1:0] activeSleepMode;
  logic asleep, wakeDone, oscReady;
  smc_pkg::smc_wake_src_t wakeSrc = '0;
  smc_pkg::smc_standby_t runInStandby = '0;
  smc_pkg::smc_gates_t gates;
  int nErrors = 0, checks = 0, n, lo;
  logic [1:0] m;
  bit exp;

  always #5 ref_clk = ~ref_clk;

  smc_sleep_sequencer #(.WAKE_CYCLES(smc_pkg::WAKE_CLK_CYCLES)) i_smc_sleep_sequencer (.ref_clk(ref_clk), .rstn(rstn),
    .ctrlWrData(ctrlWrData), .ctrlWrEn(ctrlWrEn), .sleepInstr(sleepInstr), .wakeSrc(wakeSrc),
    .runInStandby(runInStandby), .debugBreak(debugBreak), .oscReady(oscReady),
    .brownoutConfigFuse(brownoutConfigFuse), .brownoutReady(brownoutReady), .ctrlRdData(ctrlRdData),
    .gates(gates), .asleep(asleep), .activeSleepMode(activeSleepMode), .wakeDone(wakeDone));
  smc_osc_model #(.START(OSC_START)) i_smc_osc_model (.ref_clk(ref_clk), .rstn(rstn),
    .oscOn(gates.mainOscOn), .oscReady(oscReady));

  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    checks++;
    if (seen !== expv)
    begin
      nErrors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic results;
    $display("checks=%0d errors=%0d", checks, nErrors);
    if (nErrors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  // mode and enable written to the control register
  task automatic wr(input logic [2:0] d);
    ctrlWrData = d;
    ctrlWrEn = 1;
    cyc(1);
    ctrlWrEn = 0;
  endtask

  task automatic slp;
    sleepInstr = 1;
    cyc(1);
    sleepInstr = 0;
  endtask

  // a hang here is cut short at lim; when the wake was mandatory it ends the run with an error
  task automatic waitDone(input int lim, input bit must, output int k);
    k = 0;
    while (wakeDone !== 1'h1 && k < lim)
    begin
      cyc(1);
      k++;
    end
    if (k == lim && must)
    begin
      nErrors++;
      results();
    end
  endtask

  // power-down keeps only the rtc oscillator, for the periodic timer
  function automatic logic [7:0] expGates(input logic [1:0] md, input smc_pkg::smc_standby_t s);
    if (md == smc_pkg::MODE_IDLE)
      return 8'h7f;
    if (md == smc_pkg::MODE_STANDBY)
      return {2'h0, s.rtc, s.configLogic, s.adc, s.timerB, s.mainOsc, s.rtcOsc};
    return 8'h01;
  endfunction

  function automatic bit wakeOk(input logic [1:0] md, input smc_pkg::smc_wake_src_t w,
    input smc_pkg::smc_standby_t s);
    bit any;
    any = w.pinChange | w.extInt | w.twoWireAddrMatch | w.periodicTimer | w.voltageMonitor;
    if (md == smc_pkg::MODE_IDLE)
      return |w;
    if (md == smc_pkg::MODE_STANDBY)
      return any | (w.configLogic & s.configLogic) | (w.serialStartFrame & s.serial)
        | (w.timerB & s.timerB) | (w.adcWindow & s.adc) | (w.comparator & s.comparator) | (w.rtc & s.rtc);
    return any | (w.configLogic & w.configLogicNoClk);
  endfunction

  initial
  begin
    void'($urandom(61));
    cyc(2);
    rstn = 1;
    chk({ctrlRdData, asleep, wakeDone}, 16'h0000); // reset state
    chk(gates, 16'h00ff); // active clocks
    for (int md = 0; md < 3; md++)
      for (int b = 0; b < 13; b++)
        if (b != 6)
        begin
          m = 2'(md);
          runInStandby = smc_pkg::smc_standby_t'($urandom);
          brownoutConfigFuse = 2'($urandom_range(2));
          wr({m, 1'h1});
          slp();
          chk(asleep, 16'h0001); // halt on sleep
          chk(activeSleepMode, m); // mode code
          chk(gates, expGates(m, runInStandby));
          cyc(3);
          chk(asleep, 16'h0001); // no source, stays asleep
          wakeSrc = '0;
          wakeSrc[b] = 1'h1;
          if (b == 7)
            wakeSrc[6] = 1'($urandom);
          exp = wakeOk(m, wakeSrc, runInStandby);
          lo = smc_pkg::WAKE_CLK_CYCLES;
          if (m != smc_pkg::MODE_IDLE && !(m == smc_pkg::MODE_STANDBY && runInStandby.mainOsc))
            lo = smc_pkg::WAKE_CLK_CYCLES + OSC_START;
          waitDone(exp ? 40 : 20, exp, n);
          if (exp)
            chk(16'(n), 16'(lo + 1)); // wake time, one more cycle for the step from sleep into waking
          else
          begin
            chk(wakeDone, 16'h0000); // source refused
            wakeSrc = '0;
            debugBreak = 1;
            waitDone(20, 1, n);
            debugBreak = 0;
          end
          chk(asleep, 16'h0000); // back to active
          wakeSrc = '0;
          cyc(1);
          chk(wakeDone, 16'h0000); // one-cycle completion
          chk(gates, 16'h00ff); // clocks restored
          chk(ctrlRdData, {m, 1'h1}); // retained control
        end
    wr({smc_pkg::MODE_STANDBY, 1'h0});
    slp();
    cyc(2);
    chk(asleep, 16'h0000); // enable clear refuses
    wr(3'h7);
    slp();
    cyc(2);
    chk(asleep, 16'h0000); // reserved mode refused
    brownoutConfigFuse = smc_pkg::BROWNOUT_WAIT_READY;
    brownoutReady = 0;
    wr({smc_pkg::MODE_IDLE, 1'h1});
    slp();
    wakeSrc.other = 1;
    waitDone(20, 0, n);
    chk(n, 16'd20); // wait for monitor
    brownoutReady = 1;
    waitDone(5, 1, n);
    wakeSrc = '0;
    brownoutConfigFuse = '0;
    cyc(1);
    wr({smc_pkg::MODE_POWER_DOWN, 1'h1});
    slp();
    cyc(2);
    rstn = 0;
    #1;
    chk({asleep, gates}, 16'h00ff); // reset leaves sleep
    cyc(2);
    rstn = 1;
    chk(ctrlRdData, 16'h0000); // restart from reset
    cyc(2);
    results();
  end
endmodule // smc_sleep_sequencer_tb_top
